//--- rtl/sacr_defs.svh
// timing and width constants for the converter sequencing and readout link
`ifndef SACR_DEFS_SVH
`define SACR_DEFS_SVH
`define SACR_CLK_PERIOD_NS     8
`define SACR_RESULT_BITS       16
`define SACR_ACQ_FAST_NS       290
`define SACR_CNV_FAST_NS       710
`define SACR_ACQ_SLOW_NS       700
`define SACR_CNV_SLOW_NS       1300
`define SACR_QUIET_NS          10
`define SACR_EN_NS             10
`define SACR_CAL_CYCLES        64
// longest time rounds down to whole cycles, with no lower clamp
`define SACR_CNV_CYCLES        (`SACR_CNV_FAST_NS / `SACR_CLK_PERIOD_NS)
// least times round up
`define SACR_ACQ_CYCLES        ((`SACR_ACQ_FAST_NS + `SACR_CLK_PERIOD_NS - 1) / `SACR_CLK_PERIOD_NS)
`define SACR_QUIET_CYCLES      ((`SACR_QUIET_NS + `SACR_CLK_PERIOD_NS - 1) / `SACR_CLK_PERIOD_NS)
// host holds start high for the full conversion time plus synchroniser slack
`define SACR_HOLD_CYCLES       (`SACR_CNV_CYCLES + 4)
`define SACR_SCLK_HALF         10
`endif

//--- rtl/sacr_pkg.sv
// types used by the device end of the converter readout link
`default_nettype none
package sacr_pkg;
  typedef logic [15:0] sacr_word_t;
endpackage : sacr_pkg
`default_nettype wire

//--- rtl/sacr_link_if.sv
// link between the converter device end and the host end
`default_nettype none
interface sacr_link_if;
  logic convert_start;      // host to device, start of conversion
  logic serial_clk;         // host to device, readout clock
  logic serial_result_out;  // device to host, result bit
  logic serial_result_oe;   // device drives the data pin
  modport device (input convert_start, input serial_clk,
                  output serial_result_out, output serial_result_oe);
  modport host   (output convert_start, output serial_clk,
                  input serial_result_out, input serial_result_oe);
endinterface : sacr_link_if
`default_nettype wire

//--- rtl/sacr_device.sv
// converter device end: calibration, acquisition/conversion phases, serial readout
// Operation
// - self-calibrate at power-up, then acquire unprompted
// - alternate acquisition and conversion, tracking during acquisition
// - rising convert_start ends acquisition
// - rising edge freezes sample, starts conversion
// - conversion always runs to completion
// - fixed internal conversion time within maximum
// - host chooses acquisition length freely
// - start falls after conversion, result then presented
// - result shifted msb first, one per clock
// - readout overlaps next acquisition
// - host leaves quiet gap before next start
// - host keeps pins quiet during conversion
// - throughput is one over acquisition plus conversion
// - serial clock fast enough for whole result
// - acquisition budget: bits times period plus overheads
// - first bit valid within enable delay; here the msb is driven three core clocks after start falls
// - result is two's complement, sign first
`include "sacr_defs.svh"
`default_nettype none
module sacr_device (
  input  wire logic        core_clk_in,        // core clock 125 MHz
  input  wire logic        sys_rst_in,         // synchronous reset, active high
  sacr_link_if.device      link,               // pins toward host
  input  wire logic [15:0] analog_sample_in,   // digitised input, two's complement
  output logic             acquiring_out,      // high while tracking input
  output logic             converting_out,     // high while converting
  output logic [15:0]      held_sample_out     // sample frozen at conversion start
);
  typedef enum {ST_CAL, ST_ACQ, ST_CNV, ST_DONE} sacr_dev_e;

  // three-stage synchronisers; edges judged on stages two and three only
  logic [2:0] cs_sync;
  logic [2:0] ck_sync;
  logic       cs_rise;
  logic       cs_fall;
  logic       ck_rise;

  sacr_dev_e            state;
  sacr_dev_e            next_state;
  logic [15:0]          cnt;
  logic [15:0]          next_cnt;
  sacr_pkg::sacr_word_t shreg;
  sacr_pkg::sacr_word_t next_shreg;
  logic [4:0]           bits_left;
  logic [4:0]           next_bits_left;
  logic                 oe;
  logic                 next_oe;
  logic                 dout;
  logic                 next_dout;
  logic [15:0]          held;
  logic [15:0]          next_held;

  assign cs_rise = cs_sync[1] & ~cs_sync[2];
  assign cs_fall = ~cs_sync[1] & cs_sync[2];
  assign ck_rise = ck_sync[1] & ~ck_sync[2];

  // pin synchronisers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cs_sync <= 3'h0;
      ck_sync <= 3'h0;
    end else begin
      cs_sync <= {cs_sync[1:0], link.convert_start};
      ck_sync <= {ck_sync[1:0], link.serial_clk};
    end
  end

  // phase sequencing and readout shifter
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_shreg     = shreg;
    next_bits_left = bits_left;
    next_oe        = oe;
    next_dout      = dout;
    next_held      = held;
    case (state)
      ST_CAL: begin
        // calibration runs on reset release with no host command
        if (cnt == 16'(`SACR_CAL_CYCLES - 1)) begin
          next_state = ST_ACQ;
          next_cnt   = 16'h0000;
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
      ST_ACQ: begin
        next_held = analog_sample_in;
        if (cs_rise) begin
          // sample is frozen as it stands when the synchronised rise is seen
          next_state = ST_CNV;
          next_cnt   = 16'h0000;
          next_oe    = 1'b0;  // abandon any unfinished readout
        end
      end
      ST_CNV: begin
        // start line ignored here: nothing cuts a conversion short
        if (cnt == 16'(`SACR_CNV_CYCLES - 1)) begin
          next_state = ST_DONE;
          next_shreg = held;
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
      ST_DONE: begin
        if (cs_fall) begin
          // present msb at once and go straight back to acquiring
          next_state     = ST_ACQ;
          next_oe        = 1'b1;
          next_dout      = shreg[15];
          next_shreg     = {shreg[14:0], 1'b0};
          next_bits_left = 5'(`SACR_RESULT_BITS - 1);
        end
      end
      default: next_state = ST_CAL;
    endcase
    // next bit follows each of the first fifteen serial clock rising edges; the sixteenth drops the enable
    if (state == ST_ACQ && oe && ck_rise) begin
      if (bits_left == 5'h00) begin
        next_oe = 1'b0;
      end else begin
        next_dout      = shreg[15];
        next_shreg     = {shreg[14:0], 1'b0};
        next_bits_left = bits_left - 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state     <= ST_CAL;
      cnt       <= 16'h0000;
      shreg     <= 16'h0000;
      bits_left <= 5'h00;
      oe        <= 1'b0;
      dout      <= 1'b0;
      held      <= 16'h0000;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      shreg     <= next_shreg;
      bits_left <= next_bits_left;
      oe        <= next_oe;
      dout      <= next_dout;
      held      <= next_held;
    end
  end

  assign link.serial_result_out = dout;
  assign link.serial_result_oe  = oe;
  assign acquiring_out          = (state == ST_ACQ);
  assign converting_out         = (state == ST_CNV);
  assign held_sample_out        = held;
endmodule : sacr_device
`default_nettype wire

//--- rtl/sacr_host.sv
// host end: drives convert start and serial clock, collects the result
`include "sacr_defs.svh"
`default_nettype none
module sacr_host (
  input  wire logic        core_clk_in,    // core clock 125 MHz
  input  wire logic        sys_rst_in,     // synchronous reset, active high
  sacr_link_if.host        link,           // pins toward device
  input  wire logic [15:0] acq_cycles_in,  // extra acquisition length, cycles
  input  wire logic        run_in,         // level: keep sampling
  output logic [15:0]      result_out,     // last collected result
  output logic             result_valid_out // one-cycle pulse per result
);
  typedef enum {HS_IDLE, HS_CNV, HS_EN, HS_SHIFT, HS_QUIET, HS_ACQ} sacr_host_e;

  sacr_host_e state;
  sacr_host_e next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [4:0]  bitn;
  logic [4:0]  next_bitn;
  logic        cs;
  logic        next_cs;
  logic        sck;
  logic        next_sck;
  logic [15:0] sh;
  logic [15:0] next_sh;
  logic [15:0] res;
  logic [15:0] next_res;
  logic        vld;
  logic        next_vld;
  logic [2:0]  d_sync;
  logic [15:0] acq_len;

  // extra acquisition on top of the minimum budget
  assign acq_len = 16'(`SACR_ACQ_CYCLES) + acq_cycles_in;

  // data pin synchroniser; only the third stage is sampled
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) d_sync <= 3'h0;
    else            d_sync <= {d_sync[1:0], link.serial_result_out};
  end

  always_comb begin
    next_state = state;
    next_cnt   = cnt + 16'h0001;
    next_bitn  = bitn;
    next_cs    = cs;
    next_sck   = sck;
    next_sh    = sh;
    next_res   = res;
    next_vld   = 1'b0;
    case (state)
      HS_IDLE: begin
        next_cnt = 16'h0000;
        if (run_in) begin
          next_state = HS_CNV;
          next_cs    = 1'b1;
        end
      end
      HS_CNV: begin
        // clock held still while converting
        next_sck = 1'b0;
        if (cnt == 16'(`SACR_HOLD_CYCLES - 1)) begin
          next_state = HS_EN;
          next_cs    = 1'b0;
          next_cnt   = 16'h0000;
        end
      end
      HS_EN: begin
        // wait for the device to present and the sync to pass the msb
        if (cnt == 16'h0007) begin
          next_state = HS_SHIFT;
          next_cnt   = 16'h0000;
          next_bitn  = 5'h00;
        end
      end
      HS_SHIFT: begin
        // sample at the end of the low half, then raise the clock
        if (cnt == 16'(`SACR_SCLK_HALF - 1)) begin
          next_cnt = 16'h0000;
          if (!sck) begin
            next_sh  = {sh[14:0], d_sync[2]};
            next_sck = 1'b1;
            next_bitn = bitn + 5'h01;
          end else begin
            next_sck = 1'b0;
            if (bitn == 5'(`SACR_RESULT_BITS)) begin
              next_state = HS_QUIET;
              next_res   = sh;
              next_vld   = 1'b1;
            end
          end
        end
      end
      HS_QUIET: begin
        if (cnt == 16'(`SACR_QUIET_CYCLES)) begin
          next_state = HS_ACQ;
          next_cnt   = 16'h0000;
        end
      end
      HS_ACQ: begin
        if (cnt >= acq_len) begin
          next_state = run_in ? HS_CNV : HS_IDLE;
          next_cs    = run_in;
          next_cnt   = 16'h0000;
        end
      end
      default: next_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= HS_IDLE;
      cnt   <= 16'h0000;
      bitn  <= 5'h00;
      cs    <= 1'b0;
      sck   <= 1'b0;
      sh    <= 16'h0000;
      res   <= 16'h0000;
      vld   <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      bitn  <= next_bitn;
      cs    <= next_cs;
      sck   <= next_sck;
      sh    <= next_sh;
      res   <= next_res;
      vld   <= next_vld;
    end
  end

  assign link.convert_start = cs;
  assign link.serial_clk    = sck;
  assign result_out         = res;
  assign result_valid_out   = vld;
endmodule : sacr_host
`default_nettype wire

//--- verif/sacr_link_sva.sv
// link checker: timing and framing of the readout link
`default_nettype none
module sacr_link_sva (
  input wire logic core_clk_in,       // core clock
  input wire logic sys_rst_in,        // sync reset
  input wire logic convert_start,     // start line
  input wire logic serial_clk,        // readout clock
  input wire logic serial_result_out, // data bit
  input wire logic serial_result_oe   // data driven
);
  logic       sck_q, next_sck_q;
  logic [4:0] rise_n, next_rise_n;
  logic [7:0] hi_n, next_hi_n, lo_n, next_lo_n;
  // hi_n and lo_n saturate so a stuck line cannot wrap them
  always_comb begin
    next_sck_q = serial_clk;
    next_rise_n = serial_result_oe ? rise_n + 5'(serial_clk & ~sck_q) : 5'h00;
    next_hi_n = convert_start ? hi_n + 8'(hi_n != 8'hFF) : 8'h00;
    next_lo_n = serial_clk ? 8'h00 : lo_n + 8'(lo_n != 8'hFF);
  end
  // helper registers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      {sck_q, rise_n, hi_n, lo_n} <= '0;
    end else begin
      {sck_q, rise_n, hi_n, lo_n} <= {next_sck_q, next_rise_n, next_hi_n, next_lo_n};
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_oe_off_conv: assert property (convert_start [*8] |-> !serial_result_oe)
    else $error("data driven while start high");
  a_oe_after_fall: assert property ($fell(convert_start) |-> ##[1:8] serial_result_oe)
    else $error("no data after start fell");
  a_bit_stable: assert property (serial_result_oe && $past(serial_result_oe) && lo_n >= 8'h04 |-> $stable(serial_result_out))
    else $error("data moved in clock low phase");
  a_bit_count: assert property (serial_result_oe |-> rise_n <= 5'h10)
    else $error("frame longer than result");
  // sixteen rises carry the frame; the sixteenth one also ends it
  a_frame_end: assert property ($fell(serial_result_oe) && !convert_start |-> rise_n == 5'h10)
    else $error("frame ended at wrong count");
  a_sck_quiet: assert property (convert_start |-> !serial_clk)
    else $error("clock running in conversion");
  a_quiet_gap: assert property ($rose(convert_start) |-> !$past(serial_clk) && !$past(serial_clk, 2))
    else $error("no quiet gap before start");
  a_hold_min: assert property ($fell(convert_start) |-> hi_n >= 8'h58)
    else $error("start released too early");
  c_start: cover property ($rose(convert_start));
  c_read: cover property ($fell(convert_start) ##[1:8] serial_result_oe);
  c_frame: cover property ($fell(serial_result_oe) && rise_n == 5'h10);
endmodule : sacr_link_sva
`default_nettype wire

//--- verif/sar_adc_convert_readout_tb.sv
// bench: two linked ends plus a device fed a rule-breaking start line
`default_nettype none
module sar_adc_convert_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_in = 1'b0;
  logic        sys_rst_in  = 1'b1;
  logic        run_in      = 1'b0;
  logic [15:0] sample_a    = 16'h1234;
  logic [15:0] sample_b    = 16'h8000;
  logic [15:0] acq_in      = 16'h0000;
  logic [15:0] result, held_a, held_b, shift_a, bits_b;
  logic        valid, acq_a, conv_b, cs_q;
  int          err_total = 0, checked = 0, n_res = 0, nbit = 0, conv_n = 0, n;
  int          exp_q[$];
  logic [15:0] edge_v[4] = '{16'h8000, 16'h7FFF, 16'h0000, 16'hFFFF};
  sacr_link_if link_a ();
  sacr_link_if link_b ();
  sacr_device sacr_device_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .link(link_a),
    .analog_sample_in(sample_a), .acquiring_out(acq_a), .converting_out(),
    .held_sample_out(held_a));
  sacr_device sacr_device_i2 (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .link(link_b), .analog_sample_in(sample_b), .acquiring_out(), .converting_out(conv_b),
    .held_sample_out(held_b));
  sacr_host sacr_host_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .link(link_a),
    .acq_cycles_in(acq_in), .run_in(run_in), .result_out(result), .result_valid_out(valid));
  sacr_link_sva sacr_link_sva_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .convert_start(link_a.convert_start), .serial_clk(link_a.serial_clk),
    .serial_result_out(link_a.serial_result_out), .serial_result_oe(link_a.serial_result_oe));
  initial {link_b.convert_start, link_b.serial_clk} = 2'h0;
  always #4 core_clk_in = ~core_clk_in;
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    checked++;
    if (got !== want) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic complete_run;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // bounded wait for a result count
  task automatic wait_res(input int k);
    for (int i = 0; i < 20000 && n_res < k; i++) @(posedge core_clk_in);
    check(16'(n_res >= k), 16'h0001);
  endtask : wait_res
  // starts are ignored in calibration, so hosts wait for acquisition
  task automatic cal_check;
    n = 0;
    while (acq_a !== 1'b1 && n < 200) begin
      @(negedge core_clk_in);
      n++;
    end
    check(16'(n >= 63 && n <= 67), 16'h0001);
  endtask : cal_check
  // own wire capture, msb first, first sixteen rises of a frame only
  always @(posedge link_a.serial_clk) begin
    if (link_a.serial_result_oe === 1'b1 && nbit < 16) begin
      shift_a <= {shift_a[14:0], link_a.serial_result_out};
      nbit++;
    end
  end
  // reference model: sample taken at each start rise, read back in order
  always @(posedge core_clk_in) begin
    cs_q <= link_a.convert_start;
    if (conv_b === 1'b1) conv_n++;
    if (sys_rst_in) exp_q.delete();
    else if (link_a.convert_start && !cs_q) begin
      exp_q.push_back(sample_a);
      nbit = 0;
    end else if (!link_a.convert_start && cs_q) check(held_a, 16'(exp_q[$]));
    if (!sys_rst_in && valid === 1'b1 && exp_q.size() > 0) begin
      check(result, 16'(exp_q[0]));
      check(shift_a, 16'(exp_q.pop_front()));
      check({15'h0, acq_a}, 16'h0001);
      n_res++;
      sample_a <= (n_res < 4) ? edge_v[n_res] : 16'($urandom);
      acq_in <= 16'($urandom_range(0, 40));
    end
  end
  // early release and a second rise must neither abort nor restart
  task automatic fault_run;
    conv_n = 0;
    link_b.convert_start <= 1'b1;
    repeat (20) @(posedge core_clk_in);
    sample_b <= 16'h7FFF;
    link_b.convert_start <= 1'b0;
    repeat (10) @(posedge core_clk_in);
    link_b.convert_start <= 1'b1;
    repeat (300) @(posedge core_clk_in);
    check(16'(conv_n), 16'h0058);
    check(held_b, 16'h8000);
    check({15'h0, link_b.serial_result_oe}, 16'h0000);
    link_b.convert_start <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    check({15'h0, link_b.serial_result_oe}, 16'h0001);
    for (int i = 0; i < 17; i++) begin
      repeat (10) @(posedge core_clk_in);
      if (i < 16) bits_b = {bits_b[14:0], link_b.serial_result_out};
      link_b.serial_clk <= 1'b1;
      repeat (10) @(posedge core_clk_in);
      link_b.serial_clk <= 1'b0;
    end
    check(bits_b, 16'h8000);
    check({15'h0, link_b.serial_result_oe}, 16'h0000);
  endtask : fault_run
  // main sequence
  initial begin
    void'($urandom(32'hF562A113));
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    cal_check();
    run_in <= 1'b1;
    wait_res(6);
    run_in <= 1'b0;
    repeat (300) @(posedge core_clk_in);
    n = n_res;
    repeat (300) @(posedge core_clk_in);
    check(16'(n_res), 16'(n));
    check({15'h0, acq_a}, 16'h0001);
    run_in <= 1'b1;
    wait_res(10);
    fault_run();
    wait (link_a.convert_start === 1'b1);
    @(posedge core_clk_in);
    run_in <= 1'b0;
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    cal_check();
    run_in <= 1'b1;
    wait_res(12);
    complete_run();
  end
  // watchdog
  initial begin
    #400us;
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : sar_adc_convert_readout_tb
`default_nettype wire
